// ===== rtl/e3_tx_defines.svh
// constants for the e3 serial transmit payload link
`ifndef E3_TX_DEFINES_SVH
`define E3_TX_DEFINES_SVH

// ****************************************************************
// frame layout and fifo size
// ****************************************************************
`define E3_FRAME_BITS      1536
`define E3_OH_BITS         12
`define E3_FIFO_DEPTH      4
`define E3_FIFO_WIDTH      8

// ****************************************************************
// device registers
// ****************************************************************
`define FOM_ADDR           8'h00
`define DEV_STAT_ADDR      8'h01
`define FRAME_CNT_ADDR     8'h02
`define FOM_RESET          8'h28
`define TRS_MSB            1
`define TRS_LSB            0
`define TRS_SLAVE          2'h1
`define TRS_MASTER         2'h2
`define DSTAT_NIB_BIT      0
`define DSTAT_RUN_BIT      1
`define DSTAT_SLIP_BIT     2

// ****************************************************************
// terminal registers
// ****************************************************************
`define TCTRL_ADDR         8'h00
`define TSTAT_ADDR         8'h01
`define TCTRL_RESET        8'h00
`define TCTRL_EN_BIT       0
`define TCTRL_SLAVE_BIT    1
`define TSTAT_UNDER_BIT    0

`endif

// ===== rtl/e3_tx_pkg.sv
// types of the e3 transmit payload link; only reg_t is used by both ends, frm_state_e by the framer end
package e3_tx_pkg;
	typedef logic [7:0] reg_t;
	typedef enum logic {st_idle, st_run} frm_state_e;
endpackage

// ===== rtl/e3_tx_if.sv
// serial payload link between terminal equipment and framer
interface e3_tx_if;
	logic frame_sync_input;
	logic serial_payload_input;
	logic overhead_indicator_output;
	logic frame_boundary_output;
	logic nibble_interface_select;

	modport device_mp (
		input  frame_sync_input,
		input  serial_payload_input,
		input  nibble_interface_select,
		output overhead_indicator_output,
		output frame_boundary_output
	);

	modport terminal_mp (
		output frame_sync_input,
		output serial_payload_input,
		output nibble_interface_select,
		input  overhead_indicator_output,
		input  frame_boundary_output
	);
endinterface

// ===== rtl/e3_fifo.sv
// small valid/ready fifo
module e3_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             sys_clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      count_ff;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count_ff != (AW+1)'(DEPTH));
	assign out_valid_o = (count_ff != '0);
	assign out_data_o  = mem_ff[rd_ptr_ff];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data_i;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			if (push && !pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end
endmodule

// ===== rtl/e3_tx_payload_terminal.sv
// terminal equipment end: serialises user bytes onto the payload link
`include "e3_tx_defines.svh"

module e3_tx_payload_terminal #(
	parameter int FRAME_BITS = `E3_FRAME_BITS,
	parameter int FIFO_DEPTH = `E3_FIFO_DEPTH
) (
	input  wire logic           sys_clk_i,
	input  wire logic           rst_i,
	e3_tx_if.terminal_mp        link,
	input  wire logic     [7:0] reg_addr_i,
	input  e3_tx_pkg::reg_t     reg_wdata_i,
	input  wire logic           reg_wr_i,
	input  wire logic           reg_rd_i,
	output e3_tx_pkg::reg_t     reg_rdata_o,
	input  wire logic     [7:0] fill_data_i,
	input  wire logic           fill_valid_i,
	output logic                fill_ready_o
);
	import e3_tx_pkg::*;

	localparam int CW = $clog2(FRAME_BITS);
	localparam logic [CW-1:0] LAST = CW'(FRAME_BITS - 1);

	reg_t          ctrl_ff;
	logic          under_ff;
	reg_t          rdata_ff;
	logic          data_ff;
	logic          sync_ff;
	logic [7:0]    shift_ff;
	logic [3:0]    bits_ff;
	logic [CW-1:0] tcnt_ff;
	logic [CW-1:0] nxt_tcnt;
	logic          enable;
	logic          slave;
	logic          hold;
	logic          take_bit;
	logic          need_byte;
	logic          f_valid;
	logic [7:0]    f_data;

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_ff <= `TCTRL_RESET;
		end else if (reg_wr_i && reg_addr_i == `TCTRL_ADDR) begin
			ctrl_ff <= reg_wdata_i;
		end
	end

	// underrun flag: a new underrun beats a write-one clear
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			under_ff <= 1'b0;
		end else if (need_byte && !f_valid) begin
			under_ff <= 1'b1;
		end else if (reg_wr_i && reg_addr_i == `TSTAT_ADDR && reg_wdata_i[`TSTAT_UNDER_BIT]) begin
			under_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_ff <= '0;
		end else if (reg_rd_i && reg_addr_i == `TCTRL_ADDR) begin
			rdata_ff <= ctrl_ff;
		end else if (reg_rd_i && reg_addr_i == `TSTAT_ADDR) begin
			rdata_ff <= reg_t'({under_ff});
		end else begin
			rdata_ff <= '0;
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign enable      = ctrl_ff[`TCTRL_EN_BIT];
	assign slave       = ctrl_ff[`TCTRL_SLAVE_BIT];

	// ****************************************************************
	// byte buffer
	// ****************************************************************
	e3_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk_i   (sys_clk_i),
		.rst_i       (rst_i),
		.in_data_i   (fill_data_i),
		.in_valid_i  (fill_valid_i),
		.in_ready_o  (fill_ready_o),
		.out_data_o  (f_data),
		.out_valid_o (f_valid),
		.out_ready_i (need_byte)
	);

	// ****************************************************************
	// serial payload out
	// ****************************************************************
	assign hold      = link.overhead_indicator_output ||
		(!slave && link.frame_boundary_output);
	assign take_bit  = enable && !hold;
	assign need_byte = take_bit && (bits_ff == 4'h0);

	// one bit per shared clock edge, msb first
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			data_ff  <= 1'b0;
			shift_ff <= 8'h00;
			bits_ff  <= 4'h0;
		end else if (!take_bit) begin
			data_ff <= 1'b0;
		end else if (bits_ff != 4'h0) begin
			data_ff  <= shift_ff[7];
			shift_ff <= {shift_ff[6:0], 1'b0};
			bits_ff  <= bits_ff - 4'h1;
		end else if (f_valid) begin
			data_ff  <= f_data[7];
			shift_ff <= {f_data[6:0], 1'b0};
			bits_ff  <= 4'h7;
		end else begin
			data_ff <= 1'b0;
		end
	end

	// ****************************************************************
	// frame start generation when the framer follows us
	// ****************************************************************
	assign nxt_tcnt = (tcnt_ff == LAST) ? '0 : tcnt_ff + 1'b1;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tcnt_ff <= LAST;
			sync_ff <= 1'b0;
		end else if (enable && slave) begin
			tcnt_ff <= nxt_tcnt;
			sync_ff <= (nxt_tcnt == '0);
		end else begin
			tcnt_ff <= LAST;
			sync_ff <= 1'b0;
		end
	end

	assign link.serial_payload_input    = data_ff;
	assign link.frame_sync_input        = sync_ff;
	assign link.nibble_interface_select = 1'b0;
endmodule

// ===== rtl/e3_tx_payload_device.sv
// framer end: e3 transmit payload input in serial local-timed modes
//
// Our own choice: the strobed register port.
`include "e3_tx_defines.svh"

module e3_tx_payload_device #(
	parameter int FRAME_BITS = `E3_FRAME_BITS,
	parameter int OH_BITS    = `E3_OH_BITS
) (
	input  wire logic           sys_clk_i,
	input  wire logic           rst_i,
	e3_tx_if.device_mp          link,
	input  wire logic     [7:0] reg_addr_i,
	input  e3_tx_pkg::reg_t     reg_wdata_i,
	input  wire logic           reg_wr_i,
	input  wire logic           reg_rd_i,
	output e3_tx_pkg::reg_t     reg_rdata_o,
	output logic                payload_bit_o,
	output logic                payload_valid_o,
	output logic                frame_start_o
);
	import e3_tx_pkg::*;

	localparam int CW = $clog2(FRAME_BITS);
	localparam logic [CW-1:0] LAST   = CW'(FRAME_BITS - 1);
	localparam logic [CW-1:0] OH_END = CW'(OH_BITS - 1);
	localparam logic [CW-1:0] PL_BEG = CW'(OH_BITS);

	reg_t          mode_ff;
	reg_t          rdata_ff;
	reg_t          frames_ff;
	logic          slip_ff;
	frm_state_e    state_ff;
	frm_state_e    nxt_state;
	logic [CW-1:0] bit_cnt_ff;
	logic [CW-1:0] cur_idx;
	logic [CW-1:0] nxt_idx;
	logic          cur_valid;
	logic          sync_prev_ff;
	logic          sync_rise;
	logic          oh_ff;
	logic          fb_ff;
	logic          pl_bit_ff;
	logic          pl_valid_ff;
	logic          fs_ff;
	logic [1:0]    trs;
	logic          slave_mode;
	logic          master_mode;
	logic          slip;

	// ****************************************************************
	// register port
	// ****************************************************************
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_ff <= `FOM_RESET;
		end else if (reg_wr_i && reg_addr_i == `FOM_ADDR) begin
			mode_ff <= reg_wdata_i;
		end
	end

	// realignment flag: a new slip beats a write-one clear
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			slip_ff <= 1'b0;
		end else if (slip) begin
			slip_ff <= 1'b1;
		end else if (reg_wr_i && reg_addr_i == `DEV_STAT_ADDR && reg_wdata_i[`DSTAT_SLIP_BIT]) begin
			slip_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			frames_ff <= '0;
		end else if (cur_valid && cur_idx == '0) begin
			frames_ff <= frames_ff + 1'b1;
		end
	end

	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_ff <= '0;
		end else if (reg_rd_i && reg_addr_i == `FOM_ADDR) begin
			rdata_ff <= mode_ff;
		end else if (reg_rd_i && reg_addr_i == `DEV_STAT_ADDR) begin
			rdata_ff <= reg_t'({slip_ff, (state_ff == st_run), link.nibble_interface_select});
		end else if (reg_rd_i && reg_addr_i == `FRAME_CNT_ADDR) begin
			rdata_ff <= frames_ff;
		end else begin
			rdata_ff <= '0;
		end
	end

	assign reg_rdata_o = rdata_ff;

	// ****************************************************************
	// mode decode
	// ****************************************************************
	assign trs         = mode_ff[`TRS_MSB:`TRS_LSB];
	assign slave_mode  = !link.nibble_interface_select && (trs == `TRS_SLAVE);
	assign master_mode = !link.nibble_interface_select && (trs == `TRS_MASTER);

	// sync shares our clock, so no synchroniser is needed
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_prev_ff <= 1'b0;
		end else begin
			sync_prev_ff <= link.frame_sync_input;
		end
	end

	assign sync_rise = link.frame_sync_input && !sync_prev_ff;

	// ****************************************************************
	// frame timing
	// ****************************************************************
	always_comb begin
		nxt_state = state_ff;
		cur_valid = 1'b0;
		cur_idx   = bit_cnt_ff;
		slip      = 1'b0;
		unique case (state_ff)
			st_idle: begin
				if (master_mode) begin
					cur_valid = 1'b1;
					cur_idx   = '0;
					nxt_state = st_run;
				end else if (slave_mode && sync_rise) begin
					cur_valid = 1'b1;
					cur_idx   = '0;
					nxt_state = st_run;
				end
			end
			st_run: begin
				if (!slave_mode && !master_mode) begin
					nxt_state = st_idle;
				end else begin
					cur_valid = 1'b1;
					if (slave_mode && sync_rise) begin
						slip    = (bit_cnt_ff != '0);
						cur_idx = '0;
					end
				end
			end
		endcase
		nxt_idx = (cur_idx == LAST) ? '0 : cur_idx + 1'b1;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= st_idle;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bit_cnt_ff <= '0;
		end else if (cur_valid) begin
			bit_cnt_ff <= nxt_idx;
		end else begin
			bit_cnt_ff <= '0;
		end
	end

	// ****************************************************************
	// indicator outputs, high in the cycle of bit nxt_idx
	// ****************************************************************
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			oh_ff <= 1'b0;
			fb_ff <= 1'b0;
		end else begin
			oh_ff <= cur_valid && (nxt_idx == LAST || nxt_idx < OH_END);
			fb_ff <= cur_valid && master_mode && (nxt_idx == LAST);
		end
	end

	assign link.overhead_indicator_output = oh_ff;
	assign link.frame_boundary_output     = fb_ff;

	// ****************************************************************
	// payload capture
	// ****************************************************************
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pl_bit_ff   <= 1'b0;
			pl_valid_ff <= 1'b0;
			fs_ff       <= 1'b0;
		end else begin
			pl_bit_ff   <= link.serial_payload_input;
			pl_valid_ff <= cur_valid && (cur_idx >= PL_BEG);
			fs_ff       <= cur_valid && (cur_idx == '0);
		end
	end

	assign payload_bit_o   = pl_bit_ff;
	assign payload_valid_o = pl_valid_ff;
	assign frame_start_o   = fs_ff;
endmodule

// ===== tb/e3_tx_checker.sv
// assertions on the e3 transmit payload link
module e3_tx_checker #(
	parameter int FRAME_BITS = 1536,
	parameter int OH_BITS    = 12
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic frame_sync_input,
	input wire logic serial_payload_input,
	input wire logic overhead_indicator_output,
	input wire logic frame_boundary_output,
	input wire logic nibble_interface_select
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] GAP = 16'(FRAME_BITS - OH_BITS);
	localparam logic [15:0] RUN = 16'(OH_BITS);
	logic        oh;
	logic        bnd;
	logic        sync;
	logic [15:0] low_cnt_ff;
	logic [15:0] hi_cnt_ff;
	logic        seen_ff;
	assign oh   = overhead_indicator_output;
	assign bnd  = frame_boundary_output;
	assign sync = frame_sync_input;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// ****************************************************************
	// run lengths of the overhead flag
	// ****************************************************************
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			low_cnt_ff <= '0;
		else
			low_cnt_ff <= oh ? 16'h0000 : low_cnt_ff + 16'h0001;
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			hi_cnt_ff <= '0;
		else
			hi_cnt_ff <= oh ? hi_cnt_ff + 16'h0001 : 16'h0000;
	end
	// first run after start may be short
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			seen_ff <= 1'b0;
		else if (!oh && hi_cnt_ff != 16'h0000)
			seen_ff <= 1'b1;
	end
	// ****************************************************************
	// properties
	// ****************************************************************
	nib_low_a: assert property (!nibble_interface_select)
		else $error("nibble select high");
	oh_run_a: assert property ($rose(oh) |-> oh[*8])
		else $error("overhead flag run too short");
	oh_gap_a: assert property ($fell(oh) |-> !oh[*8])
		else $error("overhead flag high in payload");
	oh_period_a: assert property ($rose(oh) && seen_ff |-> low_cnt_ff == GAP)
		else $error("overhead flag gap wrong");
	oh_len_a: assert property ($fell(oh) && seen_ff |-> hi_cnt_ff == RUN)
		else $error("overhead flag length wrong");
	bnd_pos_a: assert property (bnd |-> $rose(oh))
		else $error("boundary not on last bit");
	bnd_one_a: assert property (bnd |=> oh && !bnd)
		else $error("boundary longer than one bit");
	payload_hold_a: assert property (oh |=> !serial_payload_input)
		else $error("payload placed on overhead");
	sync_one_a: assert property (sync |=> !sync)
		else $error("sync longer than one bit");
	sync_pos_a: assert property (sync && seen_ff |-> $past(oh) && !$past(oh, 2))
		else $error("sync not on first bit");
endmodule

// ===== tb/tb_top.sv
// self-checking bench for both ends of the e3 transmit payload link
`include "e3_tx_defines.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import e3_tx_pkg::*;
	localparam int FB = 64;
	localparam int NB = 40;
	logic       sys_clk_i  = 1'b0;
	logic       rst_i      = 1'b1;
	logic [7:0] reg_addr   = 8'h00;
	reg_t       reg_wdata  = 8'h00;
	logic       d_wr       = 1'b0;
	logic       d_rd       = 1'b0;
	logic       t_wr       = 1'b0;
	logic       t_rd       = 1'b0;
	logic [7:0] fill_data  = 8'h00;
	logic       fill_valid = 1'b0;
	logic       sync_q     = 1'b0;
	logic       slave_on   = 1'b0;
	reg_t       d_rdata;
	reg_t       t_rdata;
	logic       fill_ready;
	logic       pbit;
	logic       pvalid;
	logic       fstart;
	int         err_total   = 0;
	int         checks_done = 0;
	int         cyc         = 0;
	int         sent        = 0;
	int         to_send     = 0;
	logic       rx[$];

	e3_tx_if link_if ();
	e3_tx_payload_device #(.FRAME_BITS(FB), .OH_BITS(`E3_OH_BITS)) e3_tx_payload_device_i (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link_if.device_mp),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(d_wr),
		.reg_rd_i(d_rd), .reg_rdata_o(d_rdata), .payload_bit_o(pbit),
		.payload_valid_o(pvalid), .frame_start_o(fstart));
	e3_tx_payload_terminal #(.FRAME_BITS(FB), .FIFO_DEPTH(`E3_FIFO_DEPTH)) e3_tx_payload_terminal_i (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link_if.terminal_mp),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(t_wr),
		.reg_rd_i(t_rd), .reg_rdata_o(t_rdata), .fill_data_i(fill_data),
		.fill_valid_i(fill_valid), .fill_ready_o(fill_ready));
	e3_tx_checker #(.FRAME_BITS(FB), .OH_BITS(`E3_OH_BITS)) e3_tx_checker_i (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.frame_sync_input(link_if.frame_sync_input),
		.serial_payload_input(link_if.serial_payload_input),
		.overhead_indicator_output(link_if.overhead_indicator_output),
		.frame_boundary_output(link_if.frame_boundary_output),
		.nibble_interface_select(link_if.nibble_interface_select));

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [7:0] pat(input int i);
		return 8'(i) * 8'h3B + 8'hA5;
	endfunction

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic give_verdict();
		if (err_total == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic reg_wr(input bit dev, input logic [7:0] a, input reg_t v);
		@(posedge sys_clk_i);
		reg_addr <= a;
		reg_wdata <= v;
		d_wr <= dev;
		t_wr <= !dev;
		@(posedge sys_clk_i);
		d_wr <= 1'b0;
		t_wr <= 1'b0;
	endtask

	task automatic reg_rd(input bit dev, input logic [7:0] a, input reg_t exp, input string what);
		@(posedge sys_clk_i);
		reg_addr <= a;
		d_rd <= dev;
		t_rd <= !dev;
		@(posedge sys_clk_i);
		d_rd <= 1'b0;
		t_rd <= 1'b0;
		#1;
		chk(what, exp, dev ? d_rdata : t_rdata);
	endtask

	task automatic start_fill(input int n);
		to_send = n;
		sent = 0;
		fill_data <= pat(0);
		fill_valid <= 1'b1;
	endtask

	// payload seen by the framer against the bytes fed, msb first
	task automatic chk_stream(input int skip, input int n);
		int         j;
		logic [7:0] b;
		chk("payload count", 8'h01, {7'h00, rx.size() >= n});
		for (int k = 0; k < n; k++) begin
			j = k + skip;
			b = pat(j / 8);
			chk("payload bit", {7'h00, b[7 - j % 8]}, {7'h00, rx[k]});
		end
	endtask

	// ****************************************************************
	// clock, feeder, collector, timeout
	// ****************************************************************
	initial forever #2 sys_clk_i = ~sys_clk_i;

	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		sync_q <= link_if.frame_sync_input;
		if (pvalid === 1'b1)
			rx.push_back(pbit);
		if (slave_on && sync_q === 1'b1)
			chk("frame start", 8'h01, {7'h00, fstart});
		if (fill_valid === 1'b1 && fill_ready === 1'b1) begin
			sent <= sent + 1;
			fill_data <= pat(sent + 1);
			fill_valid <= (sent + 1 < to_send);
		end
		if (cyc == 6000) begin
			err_total++;
			give_verdict();
		end
	end

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic reset_values();
		reg_rd(1, `FOM_ADDR, `FOM_RESET, "device mode");
		reg_rd(0, `TCTRL_ADDR, `TCTRL_RESET, "terminal control");
		reg_rd(1, `DEV_STAT_ADDR, 8'h00, "device status");
		reg_rd(1, 8'h07, 8'h00, "unmapped read");
	endtask

	task automatic slave_run();
		reg_wr(1, `FOM_ADDR, {6'h0A, `TRS_SLAVE});
		start_fill(NB);
		repeat (12) @(posedge sys_clk_i);
		chk("fifo accepted", 8'(`E3_FIFO_DEPTH), 8'(sent));
		slave_on = 1'b1;
		reg_wr(0, `TCTRL_ADDR, 8'h03);
		while (sent < NB) @(posedge sys_clk_i);
		repeat (2 * FB) @(posedge sys_clk_i);
		// two bits of the first frame fall before the first announcement
		chk_stream(2, NB * 8 - 2);
		reg_rd(1, `DEV_STAT_ADDR, 8'h02, "device status");
		reg_rd(0, `TSTAT_ADDR, 8'h01, "terminal underrun");
		slave_on = 1'b0;
		// stop the terminal so no new underrun races the clear
		reg_wr(0, `TCTRL_ADDR, `TCTRL_RESET);
		reg_wr(0, `TSTAT_ADDR, 8'h01);
		reg_rd(0, `TSTAT_ADDR, 8'h00, "underrun cleared");
	endtask

	task automatic master_run();
		@(posedge sys_clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		start_fill(NB);
		reg_wr(1, `FOM_ADDR, {6'h0A, `TRS_MASTER});
		for (int i = 0; i < FB + 8 && link_if.frame_boundary_output !== 1'b1; i++)
			@(negedge sys_clk_i);
		chk("boundary seen", 8'h01, {7'h00, link_if.frame_boundary_output});
		// one frame started since the mode write
		reg_rd(1, `FRAME_CNT_ADDR, 8'h01, "frame count");
		reg_wr(0, `TCTRL_ADDR, 8'h01);
		// drop bits of the idle frame before the terminal ran
		@(negedge sys_clk_i);
		rx.delete();
		while (sent < NB) @(posedge sys_clk_i);
		repeat (2 * FB) @(posedge sys_clk_i);
		chk_stream(0, NB * 8);
		reg_rd(1, `DEV_STAT_ADDR, 8'h02, "device status");
	endtask

	initial begin
		repeat (8) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		reset_values();
		slave_run();
		master_run();
		give_verdict();
	end
endmodule
